// >>> verilog/dau_pkg.sv
// dau_pkg: register map, field layout and encodings for the channel
// address-update block.
// assumes: 32-bit apb, one channel, byte addresses.
package dau_pkg;

	// =========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_SRC_ADDR = 8'h00;
	localparam logic [7:0] OFS_DST_ADDR = 8'h04;
	localparam logic [7:0] OFS_OFFSET = 8'h08;
	localparam logic [7:0] OFS_ADDR_CTRL = 8'h0c;
	localparam logic [7:0] OFS_MODE_CTRL = 8'h10;
	localparam logic [7:0] OFS_REPEAT = 8'h14;

	// =========================================================
	// address control register field positions
	localparam int ACR_SRC_SEL_LO = 0;
	localparam int ACR_DST_SEL_LO = 2;
	localparam int ACR_SRC_RPT = 4;
	localparam int ACR_SRC_IE = 5;
	localparam int ACR_DST_IE = 6;
	localparam int ACR_SRC_WIN_LO = 8;
	localparam int ACR_DST_WIN_LO = 16;

	// mode control register field positions
	localparam int MCR_ENABLE = 0;
	localparam int MCR_SIZE_LO = 1;
	localparam int MCR_BLOCK = 3;
	localparam int MCR_REPEAT = 4;
	localparam int MCR_OVF_IE = 8;
	localparam int MCR_OVF_FLAG = 9;
	localparam int MCR_RPT_FLAG = 10;

	// reset values
	localparam logic [31:0] RST_ADDR = 32'h0000_0000;
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [15:0] RST_CNT = 16'h0000;

	// =========================================================
	// update selector and access size encodings
	typedef enum logic [1:0] {
		UPD_HOLD = 2'h0,
		UPD_OFFSET = 2'h1,
		UPD_INC = 2'h2,
		UPD_DEC = 2'h3
	} dau_upd_t;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2
	} dau_size_t;

	// per-side address update settings
	typedef struct packed {
		dau_upd_t sel;
		logic [4:0] win;
		logic report;
	} dau_side_t;

	// result of one side's update
	typedef struct packed {
		logic [31:0] addr;
		logic ovf;
	} dau_res_t;

	// state of the channel sequencer
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RUN = 2'h1,
		ST_DEFER = 2'h3
	} dau_state_t;

endpackage

// >>> verilog/dau_top.sv
// dau_top: address-update logic of one dma channel with apb registers.
// assumes: the bus cycle engine pulses xfer_done once per transferred
// access-size unit and reports block_last on the final unit of a block.
//
// Functional notes
// - separate wrap windows for source and destination
// - five-bit window size fields in address control
// - wrapped address cycles within its window
// - source wrap with report sets flag, stops
// - interrupt only when overflow interrupt enabled
// - destination wrap with report handled likewise
// - block mode defers overflow stop until block end
// - hold, increment, decrement or offset per side
// - step is one, two or four
// - offset step independent of access size
// - offset add wraps modulo address width
// - hold mode keeps address unchanged
// - source repeat end reloads start, pauses
// - resume continues from preserved state
// - selector 00 hold 01 offset 10 inc 11 dec
// - size 00 byte 01 word 10 longword
// - bits above window stay fixed
//
// The register addresses and the APB interface to the registers were left to the implementer.

// =============================================================
// one side's next address calculation
module dau_side_calc (
	// settings
	input wire dau_pkg::dau_side_t cfg,
	input wire dau_pkg::dau_size_t size,
	input wire logic [31:0] offset,
	// address in and out
	input wire logic [31:0] cur,
	output dau_pkg::dau_res_t res
);
	logic [31:0] step;
	logic [32:0] raw;
	logic [31:0] mask;
	logic [32:0] wide_mask;
	logic [32:0] masked_old;
	logic [32:0] masked_new;
	logic win_on;

	// step per access size, byte 1 word 2 long 4
	assign step = (size == dau_pkg::SZ_LONG) ? 32'h0000_0004 :
		(size == dau_pkg::SZ_WORD) ? 32'h0000_0002 :
		32'h0000_0001;

	// adder is 33 bits with the top bit dropped, so negative offsets wrap naturally
	always_comb begin
		case (cfg.sel)
			dau_pkg::UPD_HOLD: raw = {1'b0, cur};
			dau_pkg::UPD_OFFSET: raw = {1'b0, cur} + {1'b0, offset};
			dau_pkg::UPD_INC: raw = {1'b0, cur} + {1'b0, step};
			dau_pkg::UPD_DEC: raw = {1'b0, cur} - {1'b0, step};
			default: raw = {1'b0, cur};
		endcase
	end

	// window of 2^code bytes; code zero means no wrap
	assign win_on = (cfg.win != 5'h00);
	assign mask = (32'h0000_0001 << cfg.win) - 32'h0000_0001;
	assign wide_mask = {1'b0, mask};
	// overflow is a carry or borrow out of the window bits
	assign masked_old = {1'b0, cur} & wide_mask;
	assign masked_new = (cfg.sel == dau_pkg::UPD_DEC) ?
		(masked_old - ({1'b0, step} & wide_mask)) :
		(cfg.sel == dau_pkg::UPD_HOLD) ? masked_old :
		(masked_old + ((raw - {1'b0, cur}) & wide_mask));

	// only bits inside the window move while it is active
	assign res.addr = win_on ? ((cur & ~mask) | (raw[31:0] & mask)) :
		raw[31:0];
	assign res.ovf = win_on && ((masked_new & ~wide_mask) != 33'h0);
endmodule // dau_side_calc

// =============================================================
module dau_top (
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// bus cycle engine
	input wire logic xfer_done,
	input wire logic block_last,
	output logic channel_enable,
	output logic [31:0] source_address,
	output logic [31:0] destination_address,
	// cpu interrupt requests
	output logic overflow_irq,
	output logic repeat_end_irq
);
	// registers
	logic [31:0] source_address_reg_ff, nxt_source_address_reg;
	logic [31:0] destination_address_reg_ff, nxt_destination_address_reg;
	logic [31:0] address_offset_reg_ff;
	logic [31:0] address_control_reg_ff;
	logic [31:0] start_addr_ff;
	logic [15:0] rpt_size_ff, rpt_cnt_ff, nxt_rpt_cnt;
	logic channel_enable_ff, nxt_channel_enable;
	logic [1:0] size_ff;
	logic block_mode_ff, repeat_mode_ff, ovf_ie_ff;
	logic window_overflow_flag_ff, nxt_ovf_flag;
	logic repeat_flag_ff, nxt_repeat_flag;
	dau_pkg::dau_state_t state_ff, nxt_state;

	// decoded settings and results
	dau_pkg::dau_side_t src_cfg, dst_cfg;
	dau_pkg::dau_res_t src_res, dst_res;
	logic wr, rd_setup;
	logic sel_src, sel_dst, sel_ofs, sel_acr, sel_mcr, sel_rpt, unmapped;
	logic [31:0] wmask, mode_word;
	logic [31:0] prdata_ff, nxt_prdata;
	logic step_now, any_ovf, ovf_stop, rpt_end, src_rpt_area;

	// =========================================================
	// apb decode: zero wait states, unmapped answers slverr
	assign wr = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign sel_src = (paddr == dau_pkg::OFS_SRC_ADDR);
	assign sel_dst = (paddr == dau_pkg::OFS_DST_ADDR);
	assign sel_ofs = (paddr == dau_pkg::OFS_OFFSET);
	assign sel_acr = (paddr == dau_pkg::OFS_ADDR_CTRL);
	assign sel_mcr = (paddr == dau_pkg::OFS_MODE_CTRL);
	assign sel_rpt = (paddr == dau_pkg::OFS_REPEAT);
	assign unmapped = ~(sel_src | sel_dst | sel_ofs | sel_acr | sel_mcr |
		sel_rpt);
	assign pready = 1'b1;
	assign pslverr = psel & penable & unmapped;
	assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
		{8{pstrb[0]}}};

	// per-side settings, fully independent fields
	assign src_cfg.sel = dau_pkg::dau_upd_t'(
		address_control_reg_ff[dau_pkg::ACR_SRC_SEL_LO +: 2]);
	assign src_cfg.win =
		address_control_reg_ff[dau_pkg::ACR_SRC_WIN_LO +: 5];
	assign src_cfg.report = address_control_reg_ff[dau_pkg::ACR_SRC_IE];
	assign dst_cfg.sel = dau_pkg::dau_upd_t'(
		address_control_reg_ff[dau_pkg::ACR_DST_SEL_LO +: 2]);
	assign dst_cfg.win =
		address_control_reg_ff[dau_pkg::ACR_DST_WIN_LO +: 5];
	assign dst_cfg.report = address_control_reg_ff[dau_pkg::ACR_DST_IE];
	assign src_rpt_area = address_control_reg_ff[dau_pkg::ACR_SRC_RPT];

	// two instances of the same calculator, one per side
	dau_side_calc u_src (
		.cfg(src_cfg),
		.size(dau_pkg::dau_size_t'(size_ff)),
		.offset(address_offset_reg_ff),
		.cur(source_address_reg_ff),
		.res(src_res)
	);
	dau_side_calc u_dst (
		.cfg(dst_cfg),
		.size(dau_pkg::dau_size_t'(size_ff)),
		.offset(address_offset_reg_ff),
		.cur(destination_address_reg_ff),
		.res(dst_res)
	);

	// =========================================================
	// transfer events; both sides fold into one overflow event
	assign step_now = xfer_done & channel_enable_ff;
	assign any_ovf = step_now & ((src_res.ovf & src_cfg.report) |
		(dst_res.ovf & dst_cfg.report));
	// in block mode the stop waits for the end of the block
	assign ovf_stop = block_mode_ff ?
		(step_now & block_last & (any_ovf | (state_ff == dau_pkg::ST_DEFER))) :
		any_ovf;
	assign rpt_end = step_now & repeat_mode_ff & src_rpt_area &
		(rpt_cnt_ff == 16'h0001);

	// =========================================================
	// next addresses; a cpu write wins over the hardware update
	always_comb begin
		nxt_source_address_reg = source_address_reg_ff;
		nxt_destination_address_reg = destination_address_reg_ff;
		if (step_now) begin
			nxt_source_address_reg = rpt_end ? start_addr_ff :
				src_res.addr;
			nxt_destination_address_reg = dst_res.addr;
		end
		if (wr & sel_src) begin
			nxt_source_address_reg = (source_address_reg_ff & ~wmask) |
				(pwdata & wmask);
		end
		if (wr & sel_dst) begin
			nxt_destination_address_reg =
				(destination_address_reg_ff & ~wmask) | (pwdata & wmask);
		end
	end

	// repeat counter reloads itself when it completes
	always_comb begin
		nxt_rpt_cnt = rpt_cnt_ff;
		if (step_now & repeat_mode_ff & src_rpt_area) begin
			nxt_rpt_cnt = rpt_end ? rpt_size_ff :
				rpt_cnt_ff - 16'h0001;
		end
		if (wr & sel_rpt & pstrb[0]) begin
			nxt_rpt_cnt = pwdata[15:0];
		end
	end

	// =========================================================
	// sequencer: run, deferred overflow inside a block, idle
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			dau_pkg::ST_IDLE: if (channel_enable_ff) nxt_state = dau_pkg::ST_RUN;
			dau_pkg::ST_RUN: nxt_state = dau_pkg::ST_RUN;
			dau_pkg::ST_DEFER: if (ovf_stop) nxt_state = dau_pkg::ST_RUN;
			default: nxt_state = dau_pkg::ST_IDLE;
		endcase
		// a unit may land while the state still shows idle after enable,
		// so a mid-block overflow is deferred from any state
		if (any_ovf & block_mode_ff & ~block_last) begin
			nxt_state = dau_pkg::ST_DEFER;
		end
		// a software stop also drops a pending deferral
		if (~channel_enable_ff & (state_ff != dau_pkg::ST_IDLE)) begin
			nxt_state = dau_pkg::ST_IDLE;
		end
	end

	// enable and sticky flags; hardware set beats software clear
	always_comb begin
		nxt_channel_enable = channel_enable_ff;
		nxt_ovf_flag = window_overflow_flag_ff;
		nxt_repeat_flag = repeat_flag_ff;
		if (wr & sel_mcr & pstrb[0]) begin
			nxt_channel_enable = pwdata[dau_pkg::MCR_ENABLE];
		end
		if (wr & sel_mcr & pstrb[1]) begin
			// write zero clears, write one keeps
			nxt_ovf_flag = window_overflow_flag_ff &
				pwdata[dau_pkg::MCR_OVF_FLAG];
			nxt_repeat_flag = repeat_flag_ff & pwdata[dau_pkg::MCR_RPT_FLAG];
		end
		if (ovf_stop) begin
			nxt_ovf_flag = 1'b1;
			nxt_channel_enable = 1'b0;
		end
		if (rpt_end) begin
			nxt_repeat_flag = 1'b1;
			nxt_channel_enable = 1'b0;
		end
	end

	// =========================================================
	// address registers; nothing is cleared on re-enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			source_address_reg_ff <= dau_pkg::RST_ADDR;
			destination_address_reg_ff <= dau_pkg::RST_ADDR;
			rpt_cnt_ff <= dau_pkg::RST_CNT;
		end else begin
			source_address_reg_ff <= nxt_source_address_reg;
			destination_address_reg_ff <= nxt_destination_address_reg;
			rpt_cnt_ff <= nxt_rpt_cnt;
		end
	end

	// software-only configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			address_offset_reg_ff <= dau_pkg::RST_CTRL;
			address_control_reg_ff <= dau_pkg::RST_CTRL;
			start_addr_ff <= dau_pkg::RST_ADDR;
			rpt_size_ff <= dau_pkg::RST_CNT;
		end else begin
			if (wr & sel_ofs) address_offset_reg_ff <=
				(address_offset_reg_ff & ~wmask) | (pwdata & wmask);
			if (wr & sel_acr) address_control_reg_ff <=
				(address_control_reg_ff & ~wmask) | (pwdata & wmask);
			// start address captured whenever software loads the source
			if (wr & sel_src) start_addr_ff <= nxt_source_address_reg;
			if (wr & sel_rpt & pstrb[2]) rpt_size_ff <= pwdata[31:16];
		end
	end

	// mode bits, enable, flags and state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			size_ff <= 2'h0;
			block_mode_ff <= 1'b0;
			repeat_mode_ff <= 1'b0;
			ovf_ie_ff <= 1'b0;
			channel_enable_ff <= 1'b0;
			window_overflow_flag_ff <= 1'b0;
			repeat_flag_ff <= 1'b0;
			state_ff <= dau_pkg::ST_IDLE;
		end else begin
			if (wr & sel_mcr & pstrb[0]) begin
				size_ff <= pwdata[dau_pkg::MCR_SIZE_LO +: 2];
				block_mode_ff <= pwdata[dau_pkg::MCR_BLOCK];
				repeat_mode_ff <= pwdata[dau_pkg::MCR_REPEAT];
			end
			if (wr & sel_mcr & pstrb[1]) ovf_ie_ff <= pwdata[dau_pkg::MCR_OVF_IE];
			channel_enable_ff <= nxt_channel_enable;
			window_overflow_flag_ff <= nxt_ovf_flag;
			repeat_flag_ff <= nxt_repeat_flag;
			state_ff <= nxt_state;
		end
	end

	// =========================================================
	// read mux from next values, so the registered copy matches what the
	// registers hold in the access phase; unused mode control bits read zero
	always_comb begin
		mode_word = 32'h0000_0000;
		mode_word[dau_pkg::MCR_ENABLE] = nxt_channel_enable;
		mode_word[dau_pkg::MCR_SIZE_LO +: 2] = size_ff;
		mode_word[dau_pkg::MCR_BLOCK] = block_mode_ff;
		mode_word[dau_pkg::MCR_REPEAT] = repeat_mode_ff;
		mode_word[dau_pkg::MCR_OVF_IE] = ovf_ie_ff;
		mode_word[dau_pkg::MCR_OVF_FLAG] = nxt_ovf_flag;
		mode_word[dau_pkg::MCR_RPT_FLAG] = nxt_repeat_flag;
	end

	// no cpu write can share a read's setup cycle, so config regs are current
	assign nxt_prdata = ~rd_setup ? 32'h0000_0000 :
		sel_src ? nxt_source_address_reg :
		sel_dst ? nxt_destination_address_reg :
		sel_ofs ? address_offset_reg_ff :
		sel_acr ? address_control_reg_ff :
		sel_mcr ? mode_word :
		sel_rpt ? {rpt_size_ff, nxt_rpt_cnt} : 32'h0000_0000;

	// read data loaded at the setup edge, zero outside the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= dau_pkg::RST_CTRL;
		end else begin
			prdata_ff <= nxt_prdata;
		end
	end

	// outputs; request levels follow the sticky flags
	assign prdata = prdata_ff;
	assign channel_enable = channel_enable_ff;
	assign source_address = source_address_reg_ff;
	assign destination_address = destination_address_reg_ff;
	assign overflow_irq = window_overflow_flag_ff & ovf_ie_ff;
	assign repeat_end_irq = repeat_flag_ff;
endmodule // dau_top

// >>> sim/dau_monitor.sv
// dau_monitor: port-level checks of the address-update block.
// assumes: bound to dau_top; address control written as whole words.
module dau_monitor (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// transfer side
	input wire logic xfer_done,
	input wire logic channel_enable,
	input wire logic [31:0] source_address,
	input wire logic [31:0] destination_address,
	input wire logic overflow_irq,
	input wire logic repeat_end_irq
);
	// ====
	// shadow of address control, needed for window and hold checks
	logic [31:0] acr_ff;
	logic [31:0] nxt_acr;
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	wire step = xfer_done && channel_enable && !wr;
	wire odd = paddr > 8'h14 || paddr[1:0] != 2'h0;
	wire [31:0] src_hi = ~((32'h1 << acr_ff[12:8]) - 32'h1);
	assign nxt_acr = (wr && paddr == dau_pkg::OFS_ADDR_CTRL) ? pwdata : acr_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			acr_ff <= 32'h0;
		else
			acr_ff <= nxt_acr;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	bus_ready_a: assert property (acc |-> pready)
		else $error("pready low in access phase");
	unmapped_err_a: assert property (acc && odd |-> pslverr && prdata == 0)
		else $error("unmapped access not refused");
	idle_quiet_a: assert property (!acc |-> !pslverr && prdata == 32'h0)
		else $error("bus outputs active outside access");
	addr_still_a: assert property (!step && !wr |=>
		$stable(source_address) && $stable(destination_address))
		else $error("address moved without a transfer");
	stop_cause_a: assert property ($fell(channel_enable) |->
		$past(xfer_done) || $past(wr))
		else $error("enable dropped without cause");
	ovf_stop_a: assert property ($rose(overflow_irq) && !$past(wr) |->
		$fell(channel_enable) && $past(xfer_done))
		else $error("overflow request without stop");
	rpt_stop_a: assert property ($rose(repeat_end_irq) && !$past(wr) |->
		$fell(channel_enable))
		else $error("repeat end without pause");
	win_upper_a: assert property (step && acr_ff[12:8] != 0 && !acr_ff[4]
		|=> ((source_address ^ $past(source_address)) & $past(src_hi)) == 0)
		else $error("bits above window changed");
	dst_hold_a: assert property (step && acr_ff[3:2] == 2'h0 |=>
		$stable(destination_address))
		else $error("held destination moved");

	cover property ($rose(overflow_irq));
	cover property ($rose(repeat_end_irq));
	cover property (acc && odd);
endmodule // dau_monitor

bind dau_top dau_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .xfer_done,
	.channel_enable, .source_address, .destination_address,
	.overflow_irq, .repeat_end_irq);

// >>> sim/dau_engine_model.sv
// dau_engine_model: stand-in bus cycle engine, one unit per pulse.
// assumes: bench raises want as a running total of units.
module dau_engine_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench control: total units, pacing, block length (0 none)
	input wire logic [7:0] want,
	input wire logic [1:0] gap,
	input wire logic [3:0] blk,
	// towards the block
	input wire logic channel_enable,
	output logic xfer_done,
	output logic block_last,
	output logic [7:0] units
);
	logic [1:0] wait_ff;
	logic [3:0] bcnt_ff;
	logic [7:0] nxt_units;
	// a unit counts only when the block takes it; one sent as it stops is lost
	assign nxt_units = units + {7'h0, xfer_done & channel_enable};
	// idle qualifier toggles so a stale level is never trusted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xfer_done <= 1'b0;
			block_last <= 1'b0;
			units <= 8'h00;
			wait_ff <= 2'h0;
			bcnt_ff <= 4'h0;
		end else begin
			units <= nxt_units;
			if (wait_ff == 2'h0 && channel_enable && nxt_units != want) begin
				wait_ff <= gap;
				xfer_done <= 1'b1;
				block_last <= blk != 4'h0 && bcnt_ff == blk - 4'h1;
				bcnt_ff <= (blk == 4'h0 || bcnt_ff == blk - 4'h1) ?
					4'h0 : bcnt_ff + 4'h1;
			end else begin
				wait_ff <= (wait_ff == 2'h0) ? 2'h0 : wait_ff - 2'h1;
				xfer_done <= 1'b0;
				block_last <= ~block_last;
			end
		end
	end
endmodule // dau_engine_model

// >>> sim/test_dma_address_update_wrap_offset.sv
// test_dma_address_update_wrap_offset: apb-driven address update checks.
// assumes: dau_top, the engine model and the monitor compiled first.
module test_dma_address_update_wrap_offset;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [3:0] stb = 4'hf;
	logic [7:0] want = 8'h00;
	logic [1:0] gap = 2'h0;
	logic [3:0] blk = 4'h0;
	logic [31:0] prdata, source_address, destination_address, rv, ex;
	logic pready, pslverr, xfer_done, block_last, channel_enable, ev;
	logic overflow_irq, repeat_end_irq;
	logic [7:0] units;
	int bad_count = 0;
	int cmp_count = 0;
	int tick = 0;

	dau_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .xfer_done,
		.block_last, .channel_enable, .source_address,
		.destination_address, .overflow_irq, .repeat_end_irq);
	dau_engine_model u_eng (.pclk, .presetn, .want, .gap, .blk,
		.channel_enable, .xfer_done, .block_last, .units);

	// 25 MHz clock; a hang is cut short after 20000 cycles
	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		tick++;
		if (tick == 20000) begin
			bad_count++;
			conclude();
		end
	end

	// ====
	// verdict and comparison
	task automatic conclude();
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, got);
		cmp_count++;
		if (got !== x) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, x, got);
		end
	endtask

	// one apb transfer; idle cycle after so psel never toggles twice
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= w ? stb : 4'h0; // reads carry no byte enables
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), x, rv);
	endtask
	task automatic prog(input logic [31:0] s, d, c, m);
		wr(dau_pkg::OFS_SRC_ADDR, s);
		wr(dau_pkg::OFS_DST_ADDR, d);
		wr(dau_pkg::OFS_ADDR_CTRL, c);
		wr(dau_pkg::OFS_MODE_CTRL, m);
	endtask
	// let the engine move k units, or until the channel stops
	task automatic run(input logic [7:0] k);
		int n;
		n = 0;
		want <= units + k;
		@(posedge pclk);
		while (units !== want && channel_enable === 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		if (n == 200) begin
			bad_count++;
			$display("[ERR] units expected %h seen %h", want, units);
		end
		// drop units a stop left over so the next enable starts clean
		want <= units;
		repeat (2) @(posedge pclk);
	endtask

	// ====
	// main sequence
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 6; i++)
			rd(8'(i * 4), 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		chk("slverr", 32'h1, {31'h0, ev});
		// every method at every size; negative offset wraps the adder
		for (int s = 0; s < 3; s++)
			for (int m = 0; m < 4; m++) begin
				wr(dau_pkg::OFS_OFFSET, 32'hfffe0001);
				prog(32'h10, 32'h200, {28'h0, 2'(m), 2'(m)}, {29'h0, 2'(s), 1'b1});
				run(8'h1);
				ex = m == 0 ? 32'h10 : m == 1 ? 32'h10 + 32'hfffe0001 :
					m == 2 ? 32'h10 + (32'h1 << s) : 32'h10 - (32'h1 << s);
				chk("src", ex, source_address);
				chk("dst", ex + 32'h1f0, destination_address);
				wr(dau_pkg::OFS_MODE_CTRL, 32'h0);
			end
		prog(32'h1238, 32'h304, 32'h0003_040a, 32'h5);
		run(8'h3);
		chk("src", 32'h1234, source_address);
		chk("dst", 32'h300, destination_address);
		wr(dau_pkg::OFS_MODE_CTRL, 32'h0);
		prog(32'h1238, 32'h304, 32'h0003_042a, 32'h5);
		run(8'h2);
		chk("src", 32'h1230, source_address);
		chk("irq", 32'h0, {31'h0, overflow_irq});
		rd(dau_pkg::OFS_MODE_CTRL, 32'h204);
		stb = 4'h1;
		wr(dau_pkg::OFS_MODE_CTRL, 32'h5);
		rd(dau_pkg::OFS_MODE_CTRL, 32'h205);
		run(8'h1);
		chk("src", 32'h1234, source_address);
		stb = 4'hf;
		wr(dau_pkg::OFS_MODE_CTRL, 32'h0);
		rd(dau_pkg::OFS_MODE_CTRL, 32'h0);
		prog(32'h0, 32'h301, 32'h0002_004c, 32'h101);
		run(8'h2);
		chk("dst", 32'h303, destination_address);
		chk("irq", 32'h1, {31'h0, overflow_irq});
		wr(dau_pkg::OFS_MODE_CTRL, 32'h0);
		prog(32'h103, 32'h203, 32'h0002_026a, 32'h101);
		run(8'h1);
		chk("src", 32'h100, source_address);
		rd(dau_pkg::OFS_MODE_CTRL, 32'h300);
		chk("irq", 32'h1, {31'h0, overflow_irq});
		wr(dau_pkg::OFS_MODE_CTRL, 32'h0);
		// slow engine, four-unit blocks starting one byte into the window
		gap <= 2'h2;
		blk <= 4'h4;
		prog(32'h101, 32'h0, 32'h0000_0222, 32'h9);
		run(8'h3);
		chk("en", 32'h1, {31'h0, channel_enable});
		run(8'h1);
		chk("src", 32'h101, source_address);
		rd(dau_pkg::OFS_MODE_CTRL, 32'h208);
		blk <= 4'h0;
		wr(dau_pkg::OFS_MODE_CTRL, 32'h0);
		wr(dau_pkg::OFS_OFFSET, 32'h10);
		wr(dau_pkg::OFS_REPEAT, 32'h0003_0003);
		prog(32'h400, 32'h500, 32'h19, 32'h15);
		run(8'h3);
		chk("src", 32'h400, source_address);
		chk("dst", 32'h50c, destination_address);
		chk("rpt", 32'h1, {31'h0, repeat_end_irq});
		wr(dau_pkg::OFS_MODE_CTRL, 32'h0);
		chk("rpt", 32'h0, {31'h0, repeat_end_irq});
		conclude();
	end
endmodule // test_dma_address_update_wrap_offset
